// ==== shared/windowed_watchdog_defines.svh ====
// How it works
// (RULE1) a 12-bit down counter loads from the reload value field
// (RULE2) the counter decrements once per slow clock divided by 128
// (RULE3) after reset reload value is 0xfff and fault reset is enabled
// (RULE4) software waits three slow clocks after a restart before writing the mode register
// (RULE5) a mode register write reloads and restarts the counter like a restart
// (RULE6) the mode register takes only its first write until processor reset
// (RULE7) a valid restart reloads the counter and restarts the prescaler at once
// (RULE8) a control write without the correct key does nothing
// (RULE9) software restarts by writing key 0xa5 with the restart bit set
// (RULE10) underflow sets its flag and drives the fault line when fault reset enabled
// (RULE11) restart above the window limit sets window error and fault, even when disabled
// (RULE12) a window limit at or above reload value allows restarts anywhere
// (RULE13) the flags raise the interrupt only while fault interrupt enable is set
// (RULE14) with fault reset enabled the fault resets processor and watchdog, clearing flags
// (RULE15) processor only reset picks processor reset (1) or all resets (0)
// (RULE16) status read or any reset clears flags, interrupt and fault line
// (RULE17) the counter stops in debug or idle state when the matching halt bit is set
// (RULE18) software disables the watchdog or reprograms its period when unused
// (RULE19) while disabled the counter holds and reports no underflow; window checks remain
`ifndef WINDOWED_WATCHDOG_DEFINES_SVH
`define WINDOWED_WATCHDOG_DEFINES_SVH

`define WDT_ADDR_W          8
`define WDT_COUNT_W         12
`define WDT_PRESCALE_DIV    128

// register byte offsets
`define WDT_OFS_CONTROL     8'h00
`define WDT_OFS_MODE        8'h04
`define WDT_OFS_STATUS      8'h08
`define WDT_OFS_IRQ_MASK    8'h0c

// control register fields
`define WDT_KEY_HI          31
`define WDT_KEY_LO          24
`define WDT_KEY_VALUE       8'ha5
`define WDT_RESTART_BIT     0

// mode register fields
`define WDT_RELOAD_HI       11
`define WDT_RELOAD_LO       0
`define WDT_FIEN_BIT        12
`define WDT_RSTEN_BIT       13
`define WDT_RPROC_BIT       14
`define WDT_DIS_BIT         15
`define WDT_WINDOW_HI       27
`define WDT_WINDOW_LO       16
`define WDT_DBGHLT_BIT      28
`define WDT_IDLEHLT_BIT     29
`define WDT_MODE_RESET      32'h3fff2fff

// status register fields
`define WDT_UNF_BIT         0
`define WDT_ERR_BIT         1
`define WDT_STATUS_RESET    2'h0
`define WDT_MASK_RESET      2'h3

`endif

// ==== shared/windowed_watchdog_pkg.sv ====
`include "windowed_watchdog_defines.svh"

package windowed_watchdog_pkg;

    typedef logic [`WDT_COUNT_W-1:0] count_t;

    typedef struct packed {
        count_t      count;
        count_t      reloadValue;
        count_t      windowLimit;
        logic        faultIrqEnable;
        logic        faultResetEnable;
        logic        processorOnlyReset;
        logic        timerDisable;
        logic        debugHalt;
        logic        idleHalt;
        logic        modeLocked;
        logic        underflowFlag;
        logic        windowErrorFlag;
        logic [1:0]  irqMask;
        logic        faultLine;
        logic        irq;
        logic        procReset;
        logic        allReset;
        logic [31:0] rdData;
    } wdt_state_s;

    typedef struct packed {
        logic       slowPrev;
        logic [6:0] divCount;
        logic       tick;
    } presc_state_s;

endpackage

// ==== hdl/slow_tick_prescaler.sv ====
`timescale 1ns/1ps
`include "windowed_watchdog_defines.svh"

module slow_tick_prescaler
    import windowed_watchdog_pkg::*;
#(
    parameter int DIV = `WDT_PRESCALE_DIV
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // slow clock level and restart
    input  wire logic slowClk,
    input  wire logic restart,
    // one pulse per DIV slow clock periods
    output logic      tick
);

    localparam logic [6:0] LAST = 7'(DIV - 1);

    presc_state_s state;
    presc_state_s next_state;

    always_comb begin
        next_state          = state;
        next_state.slowPrev = slowClk;
        next_state.tick     = 1'b0;
        if (restart) begin
            next_state.divCount = 7'h00; // RULE7
        end else if (slowClk && !state.slowPrev) begin
            if (state.divCount == LAST) begin
                next_state.divCount = 7'h00;
                next_state.tick     = 1'b1; // RULE2
            end else begin
                next_state.divCount = state.divCount + 7'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick = state.tick;

endmodule // slow_tick_prescaler

// ==== hdl/windowed_watchdog_timer.sv ====
`timescale 1ns/1ps
`include "windowed_watchdog_defines.svh"

module windowed_watchdog_timer
    import windowed_watchdog_pkg::*;
#(
    parameter int ADDR_W = `WDT_ADDR_W,
    parameter int DIV    = `WDT_PRESCALE_DIV
) (
    // clock and resets
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              procRst,
    // slow clock, sampled as a level
    input  wire logic              slowClk,
    // processor state
    input  wire logic              debugState,
    input  wire logic              idleState,
    // register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [31:0]       wrData,
    input  wire logic              wrEn,
    input  wire logic              rdEn,
    output logic [31:0]            rdData,
    // fault and reset requests
    output logic                   faultLine,
    output logic                   procReset,
    output logic                   allReset,
    // interrupt
    output logic                   irq
);

    wdt_state_s state;
    wdt_state_s next_state;
    logic       tick;
    logic       restartNow;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0]        ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction

    function automatic logic [31:0] packMode(input wdt_state_s s);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[`WDT_RELOAD_HI:`WDT_RELOAD_LO] = s.reloadValue;
        v[`WDT_FIEN_BIT]                 = s.faultIrqEnable;
        v[`WDT_RSTEN_BIT]                = s.faultResetEnable;
        v[`WDT_RPROC_BIT]                = s.processorOnlyReset;
        v[`WDT_DIS_BIT]                  = s.timerDisable;
        v[`WDT_WINDOW_HI:`WDT_WINDOW_LO] = s.windowLimit;
        v[`WDT_DBGHLT_BIT]               = s.debugHalt;
        v[`WDT_IDLEHLT_BIT]              = s.idleHalt;
        packMode = v;
    endfunction

    function automatic wdt_state_s resetState();
        wdt_state_s  s;
        logic [31:0] m;
        logic [1:0]  st;
        s                    = '0;
        m                    = `WDT_MODE_RESET;
        st                   = `WDT_STATUS_RESET;
        s.reloadValue        = m[`WDT_RELOAD_HI:`WDT_RELOAD_LO]; // RULE3
        s.count              = m[`WDT_RELOAD_HI:`WDT_RELOAD_LO]; // RULE1
        s.faultIrqEnable     = m[`WDT_FIEN_BIT];
        s.faultResetEnable   = m[`WDT_RSTEN_BIT]; // RULE3
        s.processorOnlyReset = m[`WDT_RPROC_BIT];
        s.timerDisable       = m[`WDT_DIS_BIT];
        s.windowLimit        = m[`WDT_WINDOW_HI:`WDT_WINDOW_LO]; // RULE12
        s.debugHalt          = m[`WDT_DBGHLT_BIT];
        s.idleHalt           = m[`WDT_IDLEHLT_BIT];
        s.underflowFlag      = st[`WDT_UNF_BIT];
        s.windowErrorFlag    = st[`WDT_ERR_BIT];
        s.irqMask            = `WDT_MASK_RESET;
        resetState = s;
    endfunction

    slow_tick_prescaler #(
        .DIV     (DIV)
    ) u_prescaler (
        .clk     (clk),
        .sys_rst (sys_rst || procRst),
        .slowClk (slowClk),
        .restart (restartNow),
        .tick    (tick)
    );

    // decode of the bus strobes
    logic ctrlWrite;
    logic modeWrite;
    logic statusWrite;
    logic maskWrite;
    logic statusRead;
    logic keyOk;
    logic restartReq;
    logic windowOpen;
    logic halted;
    logic running;
    logic setUnderflow;
    logic setWindowError;

    always_comb begin
        ctrlWrite   = wrEn && hit(addr, `WDT_OFS_CONTROL);
        modeWrite   = wrEn && hit(addr, `WDT_OFS_MODE);
        statusWrite = wrEn && hit(addr, `WDT_OFS_STATUS);
        maskWrite   = wrEn && hit(addr, `WDT_OFS_IRQ_MASK);
        statusRead  = rdEn && hit(addr, `WDT_OFS_STATUS);
        keyOk       = wrData[`WDT_KEY_HI:`WDT_KEY_LO] == `WDT_KEY_VALUE; // RULE8
        restartReq  = ctrlWrite && keyOk && wrData[`WDT_RESTART_BIT]; // RULE9
        // a limit at or above the reload value opens the whole range
        windowOpen  = (state.windowLimit >= state.reloadValue)
                   || (state.count <= state.windowLimit); // RULE12
        halted      = (state.debugHalt && debugState)
                   || (state.idleHalt && idleState); // RULE17
        running     = !state.timerDisable && !halted; // RULE19
    end

    always_comb begin
        next_state     = state;
        restartNow     = 1'b0;
        setUnderflow   = 1'b0;
        setWindowError = 1'b0;

        // counting
        if (tick && running) begin
            if (state.count == '0) begin
                setUnderflow     = 1'b1; // RULE10
                next_state.count = state.reloadValue;
            end else begin
                next_state.count = state.count - count_t'(1); // RULE2
            end
        end

        // restart through the control register
        if (restartReq) begin
            if (windowOpen) begin
                next_state.count = state.reloadValue; // RULE7
                restartNow       = 1'b1; // RULE7
            end else begin
                // checked even when disabled; the counter is not reloaded
                setWindowError = 1'b1; // RULE11
            end
        end

        // first mode write only; later writes are dropped silently
        if (modeWrite && !state.modeLocked) begin
            next_state.modeLocked         = 1'b1; // RULE6
            next_state.reloadValue        = wrData[`WDT_RELOAD_HI:`WDT_RELOAD_LO];
            next_state.faultIrqEnable     = wrData[`WDT_FIEN_BIT];
            next_state.faultResetEnable   = wrData[`WDT_RSTEN_BIT];
            next_state.processorOnlyReset = wrData[`WDT_RPROC_BIT];
            next_state.timerDisable       = wrData[`WDT_DIS_BIT];
            next_state.windowLimit        = wrData[`WDT_WINDOW_HI:`WDT_WINDOW_LO];
            next_state.debugHalt          = wrData[`WDT_DBGHLT_BIT];
            next_state.idleHalt           = wrData[`WDT_IDLEHLT_BIT];
            // new parameters take effect at once, no window check
            next_state.count              = wrData[`WDT_RELOAD_HI:`WDT_RELOAD_LO]; // RULE5
            restartNow                    = 1'b1; // RULE5
        end

        if (maskWrite) begin
            next_state.irqMask = wrData[`WDT_ERR_BIT:`WDT_UNF_BIT];
        end

        // status clear by read, or by writing ones; a new event wins
        if (statusRead) begin
            next_state.underflowFlag   = 1'b0; // RULE16
            next_state.windowErrorFlag = 1'b0; // RULE16
            next_state.faultLine       = 1'b0; // RULE16
        end
        if (statusWrite) begin
            if (wrData[`WDT_UNF_BIT]) begin
                next_state.underflowFlag = 1'b0;
            end
            if (wrData[`WDT_ERR_BIT]) begin
                next_state.windowErrorFlag = 1'b0;
            end
            if (!next_state.underflowFlag && !next_state.windowErrorFlag) begin
                next_state.faultLine = 1'b0;
            end
        end
        if (setUnderflow) begin
            next_state.underflowFlag = 1'b1; // RULE10
            if (state.faultResetEnable) begin
                next_state.faultLine = 1'b1; // RULE10
            end
        end
        if (setWindowError) begin
            next_state.windowErrorFlag = 1'b1; // RULE11
            next_state.faultLine       = 1'b1; // RULE11
        end

        // interrupt, gated by enable and mask
        next_state.irq = next_state.faultIrqEnable
                      && |({next_state.windowErrorFlag, next_state.underflowFlag}
                           & next_state.irqMask); // RULE13

        // reset requests; the reset controller answers on procRst
        next_state.procReset = next_state.faultLine && next_state.faultResetEnable
                            && next_state.processorOnlyReset; // RULE15
        next_state.allReset  = next_state.faultLine && next_state.faultResetEnable
                            && !next_state.processorOnlyReset; // RULE14 RULE15

        // read data, valid for one cycle after the strobe
        next_state.rdData = 32'h0000_0000;
        if (rdEn) begin
            if (hit(addr, `WDT_OFS_MODE)) begin
                next_state.rdData = packMode(state);
            end else if (hit(addr, `WDT_OFS_STATUS)) begin
                next_state.rdData[`WDT_UNF_BIT] = state.underflowFlag;
                next_state.rdData[`WDT_ERR_BIT] = state.windowErrorFlag;
            end else if (hit(addr, `WDT_OFS_IRQ_MASK)) begin
                next_state.rdData[`WDT_ERR_BIT:`WDT_UNF_BIT] = state.irqMask;
            end
        end
    end

    // processor reset, including one caused by this block, restores defaults
    always_ff @(posedge clk) begin
        if (sys_rst || procRst) begin
            state <= resetState(); // RULE14 RULE16 RULE6
        end else begin
            state <= next_state;
        end
    end

    assign rdData    = state.rdData;
    assign faultLine = state.faultLine;
    assign procReset = state.procReset;
    assign allReset  = state.allReset;
    assign irq       = state.irq;

endmodule // windowed_watchdog_timer

// ==== tb/windowed_watchdog_timer_props.sv ====
`timescale 1ns/1ps

module windowed_watchdog_timer_checker #(
    parameter int ADDR_W = 8
) (
    // clock and resets
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire logic              procRst,
    // slow clock and processor state
    input wire logic              slowClk,
    input wire logic              debugState,
    input wire logic              idleState,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0]       wrData,
    input wire logic              wrEn,
    input wire logic              rdEn,
    input wire logic [31:0]       rdData,
    // fault, resets and interrupt
    input wire logic              faultLine,
    input wire logic              procReset,
    input wire logic              allReset,
    input wire logic              irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst || procRst);

    property p_rd_idle; !$past(rdEn) |-> rdData == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside a read");
    property p_no_data; $past(rdEn) && ($past(addr) == 8'h00 || $past(addr) > 8'h0c) |-> rdData == 32'h0; endproperty
    a_no_data: assert property (p_no_data) else $error("write-only or unmapped read not zero");
    property p_sr_upper; $past(rdEn) && $past(addr) == 8'h08 |-> rdData[31:2] == 30'h0; endproperty
    a_sr_upper: assert property (p_sr_upper) else $error("status read upper bits set");
    property p_sr_clear; $past(rdEn) && $past(addr) == 8'h08 |-> !faultLine && !irq; endproperty
    a_sr_clear: assert property (p_sr_clear) else $error("status read left fault or irq");
    property p_fault_hold; faultLine && !rdEn && !wrEn |=> faultLine; endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault line dropped without a clear");
    property p_irq_hold; irq && !rdEn && !wrEn |=> irq; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without a clear");
    property p_one_reset; !(procReset && allReset); endproperty
    a_one_reset: assert property (p_one_reset) else $error("both reset requests high");
    property p_fell_clear; $fell(faultLine) |-> ##[0:1] (!procReset && !allReset); endproperty
    a_fell_clear: assert property (p_fell_clear) else $error("reset request outlived fault");
endmodule // windowed_watchdog_timer_checker

// ==== tb/windowed_watchdog_timer_tb_top.sv ====
`timescale 1ns/1ps

module windowed_watchdog_timer_tb_top;
    import windowed_watchdog_pkg::*;

    logic        clk, sys_rst, procRst, slowClk, debugState, idleState;
    logic        wrEn, rdEn, faultLine, procReset, allReset, irq;
    logic [7:0]  addr;
    logic [31:0] wrData, rdData, d;
    int          errors, comparisons, n, sc;

    // short divider keeps each count in the tens of cycles
    windowed_watchdog_timer #(.DIV(4)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .procRst(procRst), .slowClk(slowClk), .debugState(debugState),
        .idleState(idleState), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
        .faultLine(faultLine), .procReset(procReset), .allReset(allReset), .irq(irq)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // slow clock of 8 cycles, one decrement every 32 cycles
    always @(posedge clk) begin
        sc <= sc + 1;
        if (sc % 4 == 3) slowClk <= ~slowClk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one idle edge after the strobe so the effect is settled on return
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wrEn <= 1'b1;
        addr <= a;
        wrData <= v;
        @(posedge clk);
        wrEn <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        rdEn <= 1'b1;
        addr <= a;
        @(posedge clk);
        rdEn <= 1'b0;
        #1;
        v = rdData;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic waitFault(input int lim);
        n = 0;
        while (faultLine !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task automatic pRst();
        @(posedge clk);
        procRst <= 1'b1;
        @(posedge clk);
        procRst <= 1'b0;
        #1;
    endtask

    task automatic stop_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic tReset();
        rd(8'h04, d);
        chk("mode reset", 32'h3fff2fff, d);
        rd(8'h08, d);
        chk("status reset", 32'h0, d);
        rd(8'h10, d);
        chk("unmapped read", 32'h0, d);
    endtask

    task automatic tUnderflow();
        pRst();
        wr(8'h04, 32'h0fff7003);
        waitFault(300);
        chk("underflow time", 1, (n >= 112 && n <= 144));
        chk("proc reset", 1, procReset);
        chk("all reset", 0, allReset);
        chk("irq", 1, irq);
        rd(8'h08, d);
        chk("status underflow", 32'h1, d);
        chk("fault cleared", 0, faultLine);
        chk("irq cleared", 0, irq);
        repeat (4) begin
            cyc(60);
            wr(8'h00, 32'ha5000001);
        end
        chk("fault after restarts", 0, faultLine);
        repeat (4) begin
            cyc(60);
            wr(8'h00, 32'h5a000001);
        end
        chk("fault after bad key", 1, faultLine);
    endtask

    task automatic tWindow();
        pRst();
        chk("reset clears", 0, {faultLine, procReset, allReset});
        wr(8'h04, 32'h0004a010);
        cyc(700);
        chk("disabled no underflow", 0, faultLine);
        wr(8'h00, 32'ha5000001);
        chk("window fault", 1, faultLine);
        chk("all reset", 1, allReset);
        chk("irq off", 0, irq);
        rd(8'h08, d);
        chk("status error", 32'h2, d);
    endtask

    task automatic tHalt();
        pRst();
        wr(8'h04, 32'h3fff3001);
        wr(8'h04, 32'h0);
        rd(8'h04, d);
        chk("mode once", 32'h3fff3001, d);
        @(posedge clk) idleState <= 1'b1;
        cyc(300);
        @(posedge clk) idleState <= 1'b0;
        @(posedge clk) debugState <= 1'b1;
        cyc(300);
        chk("halted", 0, faultLine);
        @(posedge clk) debugState <= 1'b0;
        waitFault(100);
        chk("resumed", 1, faultLine);
        chk("irq", 1, irq);
        wr(8'h0c, 32'h0);
        chk("irq masked", 0, irq);
        wr(8'h0c, 32'h3);
        chk("irq unmasked", 1, irq);
        wr(8'h08, 32'h1);
        chk("irq cleared", 0, irq);
    endtask

    initial begin
        errors = 0;
        comparisons = 0;
        sc = 0;
        sys_rst = 1'b1;
        procRst = 1'b0;
        slowClk = 1'b0;
        debugState = 1'b0;
        idleState = 1'b0;
        addr = 8'h00;
        wrData = 32'h0;
        wrEn = 1'b0;
        rdEn = 1'b0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        tReset();
        tUnderflow();
        tWindow();
        tHalt();
        stop_test();
    end

    // the tests need about 2000 cycles
    initial begin
        #250000;
        errors++;
        stop_test();
    end
endmodule // windowed_watchdog_timer_tb_top

bind windowed_watchdog_timer windowed_watchdog_timer_checker #(.ADDR_W(ADDR_W)) i_chk (
    .clk(clk), .sys_rst(sys_rst), .procRst(procRst), .slowClk(slowClk), .debugState(debugState),
    .idleState(idleState), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
    .faultLine(faultLine), .procReset(procReset), .allReset(allReset), .irq(irq)
);
